// File: shared/lineout_pkg.sv
// Shared constants for the line output stage enable register and its host
package lineout_pkg;
    // Register map
    localparam logic [7:0] STAGE_CTRL_OFS   = 8'h5e;
    localparam logic [7:0] STAGE_CTRL_RESET = 8'h00;
    // Field positions, left channel in the upper nibble
    localparam int LEFT_SHORT_REMOVE_BIT  = 7;
    localparam int LEFT_FINAL_STAGE_BIT   = 6;
    localparam int LEFT_MIDDLE_STAGE_BIT  = 5;
    localparam int LEFT_FIRST_STAGE_BIT   = 4;
    localparam int RIGHT_SHORT_REMOVE_BIT = 3;
    localparam int RIGHT_FINAL_STAGE_BIT  = 2;
    localparam int RIGHT_MIDDLE_STAGE_BIT = 1;
    localparam int RIGHT_FIRST_STAGE_BIT  = 0;
    // Offsets of each field within a channel nibble
    localparam int FIRST_OFS  = 0;
    localparam int MIDDLE_OFS = 1;
    localparam int FINAL_OFS  = 2;
    localparam int SHORT_OFS  = 3;
    localparam int LEFT_NIBBLE_BASE  = 4;
    localparam int RIGHT_NIBBLE_BASE = 0;
    localparam logic [7:0] LEFT_NIBBLE_MASK  = 8'hf0;
    localparam logic [7:0] RIGHT_NIBBLE_MASK = 8'h0f;
    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STAGE_GAP_US   = 20;
    localparam int STAGE_GAP_CYC  = (STAGE_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CNT_W      = 12;
endpackage

// File: shared/lineout_if.sv
// Control write port between the host controller and the stage register
`timescale 1ns/10ps
`default_nettype none
interface lineout_if;
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    modport device (
        input  wr_en,
        input  addr,
        input  wr_data,
        output rd_data
    );
    modport host (
        output wr_en,
        output addr,
        output wr_data,
        input  rd_data
    );
endinterface
`default_nettype wire

// File: logic/stage_gap_timer.sv
// Minimum gap timer between stage enable writes
`timescale 1ns/10ps
`default_nettype none
module stage_gap_timer (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Control
    input  wire logic start,
    output logic      elapsed
);
    import lineout_pkg::*;

    logic [GAP_CNT_W-1:0] count_ff;
    logic [GAP_CNT_W-1:0] nxt_count;
    logic                 elapsed_ff;
    logic                 nxt_elapsed;

    // Reload on start, count down to zero
    always_comb begin
        nxt_count   = count_ff;
        nxt_elapsed = elapsed_ff;
        if (start) begin
            nxt_count   = GAP_CNT_W'(STAGE_GAP_CYC - 1);
            nxt_elapsed = 1'b0;
        end else if (count_ff != '0) begin
            nxt_count = count_ff - 1'b1;
        end else begin
            nxt_elapsed = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_ff   <= '0;
            elapsed_ff <= 1'b0;
        end else begin
            count_ff   <= nxt_count;
            elapsed_ff <= nxt_elapsed;
        end
    end

    assign elapsed = elapsed_ff;
endmodule
`default_nettype wire

// File: logic/lineout_host.sv
// Host controller that sequences line output stage power up and down
// Notes on behaviour
// [R1] Bit 7 removes the left output short
// [R2] Bit 3 removes the right output short
// [R3] Bits 6 and 2 enable output stages
// [R4] Bits 5 and 1 enable intermediate stages
// [R5] Bits 4 and 0 enable input stages
// [R6] Input stage enable is written first
// [R7] Intermediate stage after path configured, before offset cancel
// [R8] Left: 20 us between input and intermediate
// [R9] Right: 20 us between input and intermediate
// [R10] Output stage only after offset cancel scheduled
// [R11] Short removal is the final write
// [R12] Gap counted on own clock, rounded up
`timescale 1ns/10ps
`default_nettype none
module lineout_host (
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   reset,
    // Register port towards the device
    lineout_if.host     bus,
    // Sequence requests
    input  wire logic   up_req,
    input  wire logic   down_req,
    input  wire logic   chan_right,
    // Signal path and offset cancellation handshake
    input  wire logic   path_ready,
    output logic        dcs_req,
    input  wire logic   dcs_sched,
    // Status
    output logic        busy,
    output logic        done,
    output logic        readback_err
);
    import lineout_pkg::*;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_FIRST  = 8'h02,
        ST_GAP    = 8'h04,
        ST_MIDDLE = 8'h08,
        ST_DCS    = 8'h10,
        ST_FINAL  = 8'h20,
        ST_SHORT  = 8'h40,
        ST_DOWN   = 8'h80
    } host_state_type;

    host_state_type state_ff;
    host_state_type nxt_state;
    logic [7:0]     shadow_ff;
    logic [7:0]     nxt_shadow;
    logic           wr_en_ff;
    logic           nxt_wr_en;
    logic [7:0]     wr_data_ff;
    logic [7:0]     nxt_wr_data;
    logic           right_ff;
    logic           nxt_right;
    logic           dcs_req_ff;
    logic           nxt_dcs_req;
    logic           done_ff;
    logic           nxt_done;
    logic           err_ff;
    logic           nxt_err;
    logic           settle_ff;
    logic           nxt_settle;
    logic           gap_start;
    logic           gap_elapsed;
    logic [2:0]     base;

    // The same timer serves both channels, since one sequence runs at a time
    stage_gap_timer i_stage_gap_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (gap_start),
        .elapsed  (gap_elapsed)
    );

    // Nibble base of the channel in progress
    assign base = right_ff ? 3'(RIGHT_NIBBLE_BASE) : 3'(LEFT_NIBBLE_BASE);

    // Sequence engine, one register write per step
    always_comb begin
        nxt_state   = state_ff;
        nxt_shadow  = shadow_ff;
        nxt_wr_en   = 1'b0;
        nxt_wr_data = wr_data_ff;
        nxt_right   = right_ff;
        nxt_dcs_req = 1'b0;
        nxt_done    = 1'b0;
        gap_start   = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_right = chan_right;
                if (down_req) begin
                    nxt_state = ST_DOWN;
                end else if (up_req) begin
                    nxt_state = ST_FIRST;
                end
            end
            ST_FIRST: begin
                // [R6] [R5] input stage first
                nxt_shadow[base + 3'(FIRST_OFS)] = 1'b1;
                nxt_wr_en   = 1'b1;
                nxt_wr_data = nxt_shadow;
                // [R12] start own-clock gap count
                gap_start   = 1'b1;
                nxt_state   = ST_GAP;
            end
            ST_GAP: begin
                // [R8] [R9] hold intermediate until 20 us
                // [R7] and until the path is configured
                if (gap_elapsed && path_ready) begin
                    nxt_state = ST_MIDDLE;
                end
            end
            ST_MIDDLE: begin
                // [R4] intermediate stage on
                nxt_shadow[base + 3'(MIDDLE_OFS)] = 1'b1;
                nxt_wr_en   = 1'b1;
                nxt_wr_data = nxt_shadow;
                // [R7] offset cancel only after intermediate
                nxt_dcs_req = 1'b1;
                nxt_state   = ST_DCS;
            end
            ST_DCS: begin
                // [R10] wait for offset cancel schedule
                if (dcs_sched) begin
                    nxt_state = ST_FINAL;
                end
            end
            ST_FINAL: begin
                // [R3] output stage on
                nxt_shadow[base + 3'(FINAL_OFS)] = 1'b1;
                nxt_wr_en   = 1'b1;
                nxt_wr_data = nxt_shadow;
                nxt_state   = ST_SHORT;
            end
            ST_SHORT: begin
                // [R11] [R1] [R2] short removal last
                nxt_shadow[base + 3'(SHORT_OFS)] = 1'b1;
                nxt_wr_en   = 1'b1;
                nxt_wr_data = nxt_shadow;
                nxt_done    = 1'b1;
                nxt_state   = ST_IDLE;
            end
            ST_DOWN: begin
                // All four bits of the channel drop in one write
                nxt_shadow  = shadow_ff &
                              (right_ff ? LEFT_NIBBLE_MASK : RIGHT_NIBBLE_MASK);
                nxt_wr_en   = 1'b1;
                nxt_wr_data = nxt_shadow;
                nxt_done    = 1'b1;
                nxt_state   = ST_IDLE;
            end
        endcase
    end

    // Readback is checked only once the device has settled after a write
    // A mismatch in the cycle of a taken request still sets the flag
    always_comb begin
        nxt_settle = wr_en_ff;
        nxt_err    = err_ff;
        if (!wr_en_ff && !settle_ff && bus.rd_data != shadow_ff) begin
            nxt_err = 1'b1;
        end else if (state_ff == ST_IDLE && (up_req || down_req)) begin
            nxt_err = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff   <= ST_IDLE;
            shadow_ff  <= STAGE_CTRL_RESET;
            wr_en_ff   <= 1'b0;
            wr_data_ff <= STAGE_CTRL_RESET;
            right_ff   <= 1'b0;
            dcs_req_ff <= 1'b0;
            done_ff    <= 1'b0;
            err_ff     <= 1'b0;
            settle_ff  <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            shadow_ff  <= nxt_shadow;
            wr_en_ff   <= nxt_wr_en;
            wr_data_ff <= nxt_wr_data;
            right_ff   <= nxt_right;
            dcs_req_ff <= nxt_dcs_req;
            done_ff    <= nxt_done;
            err_ff     <= nxt_err;
            settle_ff  <= nxt_settle;
        end
    end

    // Outputs
    assign bus.wr_en     = wr_en_ff;
    assign bus.addr      = STAGE_CTRL_OFS;
    assign bus.wr_data   = wr_data_ff;
    assign dcs_req       = dcs_req_ff;
    assign done          = done_ff;
    assign busy          = (state_ff != ST_IDLE);
    assign readback_err  = err_ff;
endmodule
`default_nettype wire

// File: logic/lineout_stage_reg.sv
// Line output stage enable register on the device side
`timescale 1ns/10ps
`default_nettype none
module lineout_stage_reg (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Register port from the host
    lineout_if.device bus,
    // Stage controls towards the analogue drivers
    output logic      left_short_remove,
    output logic      left_final_stage_on,
    output logic      left_middle_stage_on,
    output logic      left_first_stage_on,
    output logic      right_short_remove,
    output logic      right_final_stage_on,
    output logic      right_middle_stage_on,
    output logic      right_first_stage_on
);
    import lineout_pkg::*;

    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    // Write decode; other addresses are not ours and are ignored
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (bus.wr_en && bus.addr == STAGE_CTRL_OFS) begin
            nxt_ctrl = bus.wr_data;
        end
        nxt_rd = (bus.addr == STAGE_CTRL_OFS) ? ctrl_ff : 8'h00;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_ff <= STAGE_CTRL_RESET;
            rd_ff   <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            rd_ff   <= nxt_rd;
        end
    end

    assign bus.rd_data = rd_ff;
    // [R1] left short removal
    assign left_short_remove     = ctrl_ff[LEFT_SHORT_REMOVE_BIT];
    // [R3] output stage enables
    assign left_final_stage_on   = ctrl_ff[LEFT_FINAL_STAGE_BIT];
    // [R4] intermediate stage enables
    assign left_middle_stage_on  = ctrl_ff[LEFT_MIDDLE_STAGE_BIT];
    // [R5] input stage enables
    assign left_first_stage_on   = ctrl_ff[LEFT_FIRST_STAGE_BIT];
    // [R2] right short removal
    assign right_short_remove    = ctrl_ff[RIGHT_SHORT_REMOVE_BIT];
    // [R3] right output stage
    assign right_final_stage_on  = ctrl_ff[RIGHT_FINAL_STAGE_BIT];
    // [R4] right intermediate stage
    assign right_middle_stage_on = ctrl_ff[RIGHT_MIDDLE_STAGE_BIT];
    // [R5] right input stage
    assign right_first_stage_on  = ctrl_ff[RIGHT_FIRST_STAGE_BIT];
endmodule
`default_nettype wire

// File: verification/lineout_link_chk.sv
// Wire checks on the host to register link
`timescale 1ns/10ps
`default_nettype none
module lineout_link_chk
    import lineout_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset,
    // Link signals
    input wire logic       wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [7:0]           last_ff;
    logic [7:0]           nxt_last;
    logic [GAP_CNT_W-1:0] gap_ff;
    logic [GAP_CNT_W-1:0] nxt_gap;
    logic [7:0]           rise;
    // Shadow of the register and cycles since an input stage write
    always_comb begin
        rise = wr_data & ~last_ff;
        nxt_last = wr_en ? wr_data : last_ff;
        nxt_gap = (&gap_ff) ? gap_ff : gap_ff + 1'b1; // Saturates, never wraps
        if (wr_en && ((rise & 8'h11) != 8'h00)) begin
            nxt_gap = '0;
        end
    end
    always_ff @(posedge core_clk) begin
        last_ff <= reset ? 8'h00 : nxt_last;
        gap_ff <= reset ? '0 : nxt_gap;
    end
    property p_addr; wr_en |-> addr == STAGE_CTRL_OFS; endproperty
    a_addr: assert property (p_addr) else $error("write to wrong address");
    property p_rd_follow; wr_en |-> ##2 rd_data == $past(wr_data, 2); endproperty
    a_rd_follow: assert property (p_rd_follow) else $error("readback lost write");
    property p_rd_hold; !$past(wr_en) |-> rd_data == last_ff; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readback drifted");
    property p_first;
        wr_en |-> (last_ff[7:4] != 4'h0 || wr_data[7:4] inside {4'h0, 4'h1})
            && (last_ff[3:0] != 4'h0 || wr_data[3:0] inside {4'h0, 4'h1});
    endproperty
    a_first: assert property (p_first) else $error("first write not input stage");
    property p_middle; wr_en |-> (rise & 8'h22 & ~(last_ff << 1)) == 8'h00; endproperty
    a_middle: assert property (p_middle) else $error("middle before input stage");
    property p_gap_left; wr_en && rise[5] |-> gap_ff + 1 >= STAGE_GAP_CYC; endproperty
    a_gap_left: assert property (p_gap_left) else $error("left gap too short");
    property p_gap_right; wr_en && rise[1] |-> gap_ff + 1 >= STAGE_GAP_CYC; endproperty
    a_gap_right: assert property (p_gap_right) else $error("right gap too short");
    property p_final; wr_en |-> (rise & 8'h44 & ~(last_ff << 1)) == 8'h00; endproperty
    a_final: assert property (p_final) else $error("output stage too early");
    property p_short; wr_en |-> (rise & 8'h88 & ~(last_ff << 1)) == 8'h00; endproperty
    a_short: assert property (p_short) else $error("short removed too early");
endmodule
`default_nettype wire

// File: verification/line_output_stage_enable_control_bench.sv
// Bench joining host and stage register across the link
`timescale 1ns/10ps
`default_nettype none
module line_output_stage_enable_control_bench;
    import lineout_pkg::*;
    logic       core_clk;
    logic       reset;
    logic       up_req, down_req, chan_right, path_ready, dcs_sched;
    logic       dcs_req, busy, done, readback_err;
    logic [7:0] outs;
    logic [7:0] wq[$];
    int         tq[$];
    int         cyc, miscompares, comparisons;
    lineout_if i_lineout_if ();
    lineout_host i_lineout_host (.core_clk(core_clk), .reset(reset), .bus(i_lineout_if),
        .up_req(up_req), .down_req(down_req), .chan_right(chan_right),
        .path_ready(path_ready), .dcs_req(dcs_req), .dcs_sched(dcs_sched),
        .busy(busy), .done(done), .readback_err(readback_err));
    lineout_stage_reg i_lineout_stage_reg (.core_clk(core_clk), .reset(reset),
        .bus(i_lineout_if), .left_short_remove(outs[7]), .left_final_stage_on(outs[6]),
        .left_middle_stage_on(outs[5]), .left_first_stage_on(outs[4]),
        .right_short_remove(outs[3]), .right_final_stage_on(outs[2]),
        .right_middle_stage_on(outs[1]), .right_first_stage_on(outs[0]));
    lineout_link_chk i_lineout_link_chk (.core_clk(core_clk), .reset(reset),
        .wr_en(i_lineout_if.wr_en), .addr(i_lineout_if.addr),
        .wr_data(i_lineout_if.wr_data), .rd_data(i_lineout_if.rd_data));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    // Log every write with its cycle number
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (i_lineout_if.wr_en === 1'b1) begin
            wq.push_back(i_lineout_if.wr_data);
            tq.push_back(cyc);
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Power up one channel; left stalls the signal path past the gap,
    // right has the path ready at once so only the gap timer holds it back
    task automatic up_seq(input logic right, input logic [7:0] base);
        int sh;
        sh = right ? 0 : 4;
        wq.delete();
        tq.delete();
        chan_right = right;
        path_ready = right;
        up_req = 1;
        step(1);
        up_req = 0;
        chk(busy, 1);
        step(right ? 1000 : 2100);
        chk(wq.size(), 1);
        chk(outs, base | (8'h1 << sh));
        path_ready = 1;
        for (int n = 0; n < 3000 && dcs_req !== 1'b1; n++) step(1);
        chk(dcs_req, 1);
        step(50);
        chk(outs, base | (8'h3 << sh));
        chk(tq[1] - tq[0] >= STAGE_GAP_CYC, 1);
        dcs_sched = 1;
        for (int n = 0; n < 100 && done !== 1'b1; n++) step(1);
        chk(done, 1);
        step(3);
        chk(outs, base | (8'hf << sh));
        for (int i = 0; i < 4; i++) chk(wq[i], base | (((8'h2 << i) - 1) << sh));
        chk(i_lineout_if.rd_data, base | (8'hf << sh));
        chk(readback_err, 0);
        path_ready = 0;
        dcs_sched = 0;
    endtask
    // Watchdog well past the expected run
    initial begin
        #500us;
        miscompares++;
        summarize();
    end
    initial begin
        {up_req, down_req, chan_right, path_ready, dcs_sched} = '0;
        reset = 1;
        step(3);
        reset = 0;
        chk(outs, STAGE_CTRL_RESET);
        chk(i_lineout_if.rd_data, 8'h00);
        up_seq(0, 8'h00);
        up_seq(1, 8'hf0);
        // Power down the left channel only; the right one keeps running
        chan_right = 0;
        down_req = 1;
        step(1);
        down_req = 0;
        for (int n = 0; n < 100 && done !== 1'b1; n++) step(1);
        step(3);
        chk(outs, 8'h0f);
        chk(i_lineout_if.rd_data, 8'h0f);
        chk(busy, 0);
        // Reset while idle after the power down must clear every stage bit again
        reset = 1;
        step(2);
        reset = 0;
        chk(outs, STAGE_CTRL_RESET);
        chk(i_lineout_if.rd_data, 8'h00);
        step(3);
        chk(readback_err, 0);
        summarize();
    end
endmodule
`default_nettype wire
